/* dcr_host_model.sv */
// Purpose: host side of the serial register link
// Assumes: SCLK idles low, 4 MCLK per phase (320 ns period)
// Notes: released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module dcr_host_model (
	input wire logic MCLK,
	output logic SCLK,
	output logic CS_N,
	output logic SDIO_DRV,
	input wire logic SDIO_LINE
);
	initial begin
		SCLK = 1'b0;
		CS_N = 1'b1;
		SDIO_DRV = 1'b0;
	end
	task automatic half();
		repeat (4) @(posedge MCLK);
	endtask
	// data moves on the rise, read bits are taken at the fall
	task automatic shift_bit(input logic b, output logic r);
		SCLK <= 1'b1;
		SDIO_DRV <= b;
		half();
		SCLK <= 1'b0;
		r = SDIO_LINE;
		half();
	endtask
	task automatic xfer(input logic [7:0] cmd, input int nb,
		input logic [23:0] wd, output logic [23:0] rd);
		logic r;
		rd = 24'h000000;
		CS_N <= 1'b0;
		half();
		for (int i = 7; i >= 0; i--) shift_bit(cmd[i], r);
		for (int i = nb * 8 - 1; i >= 0; i--) begin
			shift_bit(wd[i], r);
			rd = {rd[22:0], r};
		end
		CS_N <= 1'b1;
		SDIO_DRV <= ~SDIO_DRV;
		half();
		half();
	endtask
endmodule
`default_nettype wire

/* dcr_pkg.sv */
// Purpose: shared constants and types for the converter register map
// Assumes: 25 MHz device clock, serial map of sixteen byte addresses
// Notes: config word layout is mirrored by dcr_cfg_t
package dcr_pkg;
	localparam int MCLK_FREQ_HZ = 25_000_000;
	localparam int SETTLE_TIME_US = 2000;
	localparam int SETTLE_CYCLES =
		(SETTLE_TIME_US * (MCLK_FREQ_HZ / 1_000_000));
	localparam int STEP_MV = 40;
	localparam int FULL_SCALE_MV = 5000;
	localparam int STEP_THRESH_CODES = (STEP_MV * 1048576) / FULL_SCALE_MV;

	localparam logic [3:0] ADDR_CODE_HI = 4'h0;
	localparam logic [3:0] ADDR_CODE_MID = 4'h1;
	localparam logic [3:0] ADDR_CODE_LO = 4'h2;
	localparam logic [3:0] ADDR_CFG_HI = 4'h4;
	localparam logic [3:0] ADDR_CFG_LO = 4'h5;
	localparam logic [3:0] ADDR_OCAL_HI = 4'h8;
	localparam logic [3:0] ADDR_OCAL_MID = 4'h9;
	localparam logic [3:0] ADDR_OCAL_LO = 4'ha;
	localparam logic [3:0] ADDR_GCAL_HI = 4'hc;
	localparam logic [3:0] ADDR_GCAL_MID = 4'hd;
	localparam logic [3:0] ADDR_GCAL_LO = 4'he;

	localparam int CMD_RW_BIT = 7;
	localparam int CMD_MB_HI = 6;
	localparam int CMD_MB_LO = 5;
	localparam int CMD_ADDR_HI = 3;
	localparam logic [1:0] MB_RESERVED = 2'h3;
	localparam logic [2:0] LAST_BIT = 3'h7;

	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_SELFCAL = 2'h1;
	localparam logic [1:0] MODE_SLEEP = 2'h2;

	localparam logic [15:0] CFG_WMASK = 16'hc2ff;
	localparam logic [15:0] CFG_RO_ONES = 16'h2800;
	localparam logic [15:0] CFG_RESET = 16'h2802;
	localparam logic [23:0] CODE_RESET = 24'h000000;
	localparam logic [23:0] OFFSET_CLEAR = 24'h000000;
	localparam logic [23:0] GAIN_CLEAR = 24'h800000;
	localparam logic [3:0] PAD16 = 4'h0;

	typedef struct packed {
		logic adaptive_filter_ctl;
		logic cal_output_connect;
		logic [3:0] rsv_13_10;
		logic cal_clear;
		logic rsv_8;
		logic resolution_sel;
		logic code_clear;
		logic code_format_sel;
		logic fast_settle_disable;
		logic byte_order_sel;
		logic bit_order_sel;
		logic [1:0] operating_mode_field;
	} dcr_cfg_t;

	typedef enum logic [1:0] {
		ST_CMD,
		ST_WDATA,
		ST_RDATA,
		ST_DROP
	} dcr_state_t;
endpackage

/* dcr_top.sv */
// Purpose: serial register map and code handling of the output converter
// Assumes: SCLK, CS_N and SDIO come from the host, asynchronous to MCLK
// Notes: SCLK must stay well below MCLK/4 for the edge sampling
`timescale 1ns/1ps
`default_nettype none
module dcr_top #(
	parameter int SETTLE_CYCLES = dcr_pkg::SETTLE_CYCLES,
	parameter int OUT_W = 20
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic SDIO_IN,
	output logic SDIO_OUT,
	output logic SDIO_OE,
	input wire logic CAL_DONE,
	input wire logic [23:0] CAL_OFFSET,
	input wire logic [23:0] CAL_GAIN,
	output logic [19:0] CODE_OUT,
	output logic CODE_UPDATE,
	output logic FAST_SETTLE,
	output logic [1:0] OP_MODE,
	output logic CAL_CONNECT,
	output logic [23:0] OFFSET_CAL,
	output logic [23:0] GAIN_CAL
);
	generate
		if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535 || OUT_W != 20) begin
			$error("dcr_top: unsupported parameter value");
		end
	endgenerate

	// synchronisers; first stages feed only second stages
	logic sclk_s1, sclk_s2, sclk_s3;
	logic cs_n_s1, cs_n_s2;
	logic sdio_s1, sdio_s2;
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			cs_n_s1 <= 1'b1;
			cs_n_s2 <= 1'b1;
			sdio_s1 <= 1'b0;
			sdio_s2 <= 1'b0;
		end else begin
			sclk_s1 <= SCLK;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			cs_n_s1 <= CS_N;
			cs_n_s2 <= cs_n_s1;
			sdio_s1 <= SDIO_IN;
			sdio_s2 <= sdio_s1;
		end
	end

	dcr_pkg::dcr_state_t state_reg;
	dcr_pkg::dcr_cfg_t cfg_reg;
	logic [7:0] rx_reg, tx_reg;
	logic [2:0] bit_reg;
	logic [1:0] left_reg;
	logic [3:0] addr_reg;
	logic [15:0] cfg_pend_reg;
	logic cfg_touch_reg, code_touch_reg;
	logic [23:0] code_reg, ocal_reg, gcal_reg;
	logic [19:0] out_reg;
	logic upd_reg, fast_reg, oe_reg, sdo_reg;
	logic [15:0] hold_reg;

	logic fall, byte_done, lsb_first;
	logic [7:0] rx_shift;
	logic [3:0] addr_step;
	assign fall = sclk_s3 & ~sclk_s2 & ~cs_n_s2;
	assign byte_done = fall && (bit_reg == dcr_pkg::LAST_BIT);
	// command byte always arrives msb first
	assign lsb_first = cfg_reg.bit_order_sel && (state_reg != dcr_pkg::ST_CMD);
	assign rx_shift = lsb_first ? {sdio_s2, rx_reg[7:1]} :
		{rx_reg[6:0], sdio_s2};
	assign addr_step = cfg_reg.byte_order_sel ? addr_reg - 4'h1 :
		addr_reg + 4'h1;

	function automatic logic [15:0] cfg_read(input dcr_pkg::dcr_cfg_t c);
		cfg_read = (c & dcr_pkg::CFG_WMASK) | dcr_pkg::CFG_RO_ONES;
	endfunction

	function automatic logic [7:0] map_byte(input logic [3:0] a,
		input logic [23:0] code, input logic [15:0] cfg,
		input logic [23:0] ocal, input logic [23:0] gcal);
		unique case (a)
			dcr_pkg::ADDR_CODE_HI: map_byte = code[23:16];
			dcr_pkg::ADDR_CODE_MID: map_byte = code[15:8];
			dcr_pkg::ADDR_CODE_LO: map_byte = code[7:0];
			dcr_pkg::ADDR_CFG_HI: map_byte = cfg[15:8];
			dcr_pkg::ADDR_CFG_LO: map_byte = cfg[7:0];
			dcr_pkg::ADDR_OCAL_HI: map_byte = ocal[23:16];
			dcr_pkg::ADDR_OCAL_MID: map_byte = ocal[15:8];
			dcr_pkg::ADDR_OCAL_LO: map_byte = ocal[7:0];
			dcr_pkg::ADDR_GCAL_HI: map_byte = gcal[23:16];
			dcr_pkg::ADDR_GCAL_MID: map_byte = gcal[15:8];
			dcr_pkg::ADDR_GCAL_LO: map_byte = gcal[7:0];
			default: map_byte = 8'h00;
		endcase
	endfunction

	function automatic logic tx_bit(input logic [7:0] b, input logic [2:0] i,
		input logic lsb);
		tx_bit = lsb ? b[i] : b[3'h7 - i];
	endfunction

	// command decode and byte sequencing
	logic [7:0] cmd_byte;
	logic [1:0] cmd_mb;
	logic [3:0] cmd_addr;
	logic cmd_rd;
	assign cmd_byte = rx_shift;
	assign cmd_mb = cmd_byte[dcr_pkg::CMD_MB_HI:dcr_pkg::CMD_MB_LO];
	assign cmd_addr = cmd_byte[dcr_pkg::CMD_ADDR_HI:0];
	assign cmd_rd = cmd_byte[dcr_pkg::CMD_RW_BIT];

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			state_reg <= dcr_pkg::ST_CMD;
			bit_reg <= 3'h0;
			rx_reg <= 8'h00;
			left_reg <= 2'h0;
			addr_reg <= 4'h0;
		end else if (cs_n_s2) begin
			// deselect aborts; an unfinished write commits no config or code output
			state_reg <= dcr_pkg::ST_CMD;
			bit_reg <= 3'h0;
		end else if (fall) begin
			bit_reg <= bit_reg + 3'h1;
			rx_reg <= rx_shift;
			if (byte_done) begin
				unique case (state_reg)
					dcr_pkg::ST_CMD: begin
						left_reg <= cmd_mb;
						addr_reg <= cmd_addr;
						if (cmd_mb == dcr_pkg::MB_RESERVED) begin
							state_reg <= dcr_pkg::ST_DROP;
						end else if (cmd_rd) begin
							state_reg <= dcr_pkg::ST_RDATA;
						end else begin
							state_reg <= dcr_pkg::ST_WDATA;
						end
					end
					dcr_pkg::ST_WDATA, dcr_pkg::ST_RDATA: begin
						if (left_reg == 2'h0) begin
							state_reg <= dcr_pkg::ST_DROP;
						end else begin
							left_reg <= left_reg - 2'h1;
							addr_reg <= addr_step;
						end
					end
					dcr_pkg::ST_DROP: state_reg <= dcr_pkg::ST_DROP;
				endcase
			end
		end
	end

	// write path: bytes land at the falling edge of their last bit
	logic wr_en, wr_last, code_hit, cfg_hit, cfg_commit, clear_normal;
	logic do_cal_clear, do_code_clear, code_upd;
	logic [15:0] cfg_merged;
	logic [23:0] code_wr, code_eff;
	dcr_pkg::dcr_cfg_t cfg_new, cfg_eff, cfg_store;
	assign wr_en = byte_done && (state_reg == dcr_pkg::ST_WDATA);
	assign wr_last = wr_en && (left_reg == 2'h0);
	// low code byte alone moves nothing at 16-bit
	assign code_hit = wr_en && ((addr_reg == dcr_pkg::ADDR_CODE_HI) ||
		(addr_reg == dcr_pkg::ADDR_CODE_MID) ||
		((addr_reg == dcr_pkg::ADDR_CODE_LO) &&
		cfg_reg.resolution_sel));
	assign cfg_hit = wr_en && ((addr_reg == dcr_pkg::ADDR_CFG_HI) ||
		(addr_reg == dcr_pkg::ADDR_CFG_LO));

	always_comb begin
		cfg_merged = cfg_pend_reg;
		code_wr = code_reg;
		if (wr_en) begin
			unique case (addr_reg)
				dcr_pkg::ADDR_CFG_HI: cfg_merged[15:8] = rx_shift;
				dcr_pkg::ADDR_CFG_LO: cfg_merged[7:0] = rx_shift;
				dcr_pkg::ADDR_CODE_HI: code_wr[23:16] = rx_shift;
				dcr_pkg::ADDR_CODE_MID: code_wr[15:8] = rx_shift;
				dcr_pkg::ADDR_CODE_LO: code_wr[7:0] = rx_shift;
				default: code_wr = code_reg;
			endcase
		end
	end

	assign cfg_commit = wr_last && (cfg_touch_reg || cfg_hit);
	assign cfg_new = dcr_pkg::dcr_cfg_t'(cfg_read(dcr_pkg::dcr_cfg_t'(
		cfg_merged)));
	assign clear_normal = cfg_commit &&
		(cfg_new.operating_mode_field == dcr_pkg::MODE_NORMAL);
	assign do_cal_clear = clear_normal && cfg_new.cal_clear;
	assign do_code_clear = clear_normal && cfg_new.code_clear;
	assign code_eff = do_code_clear ? dcr_pkg::CODE_RESET : code_wr;
	assign cfg_eff = cfg_commit ? cfg_new : cfg_reg;
	assign code_upd = (wr_last && (code_touch_reg || code_hit)) ||
		do_code_clear;

	// the clear bits act once and read back zero in normal mode
	always_comb begin
		cfg_store = cfg_new;
		if (clear_normal) begin
			cfg_store.cal_clear = 1'b0;
			cfg_store.code_clear = 1'b0;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			cfg_reg <= dcr_pkg::dcr_cfg_t'(dcr_pkg::CFG_RESET);
			cfg_pend_reg <= dcr_pkg::CFG_RESET;
			cfg_touch_reg <= 1'b0;
			code_touch_reg <= 1'b0;
		end else begin
			if (byte_done && state_reg == dcr_pkg::ST_CMD) begin
				cfg_pend_reg <= cfg_read(cfg_reg);
				cfg_touch_reg <= 1'b0;
				code_touch_reg <= 1'b0;
			end else begin
				cfg_pend_reg <= cfg_merged;
				cfg_touch_reg <= cfg_touch_reg | cfg_hit;
				code_touch_reg <= code_touch_reg | code_hit;
			end
			if (cfg_commit) begin
				cfg_reg <= cfg_store;
			end else if (CAL_DONE && cfg_reg.operating_mode_field ==
				dcr_pkg::MODE_SELFCAL) begin
				cfg_reg.operating_mode_field <= dcr_pkg::MODE_NORMAL;
			end
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			code_reg <= dcr_pkg::CODE_RESET;
		end else begin
			code_reg <= code_eff;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ocal_reg <= dcr_pkg::OFFSET_CLEAR;
			gcal_reg <= dcr_pkg::GAIN_CLEAR;
		end else if (do_cal_clear) begin
			ocal_reg <= dcr_pkg::OFFSET_CLEAR;
			gcal_reg <= dcr_pkg::GAIN_CLEAR;
		end else if (wr_en) begin
			unique case (addr_reg)
				dcr_pkg::ADDR_OCAL_HI: ocal_reg[23:16] <= rx_shift;
				dcr_pkg::ADDR_OCAL_MID: ocal_reg[15:8] <= rx_shift;
				dcr_pkg::ADDR_OCAL_LO: ocal_reg[7:0] <= rx_shift;
				dcr_pkg::ADDR_GCAL_HI: gcal_reg[23:16] <= rx_shift;
				dcr_pkg::ADDR_GCAL_MID: gcal_reg[15:8] <= rx_shift;
				dcr_pkg::ADDR_GCAL_LO: gcal_reg[7:0] <= rx_shift;
				default: ocal_reg <= ocal_reg;
			endcase
		end else if (CAL_DONE && cfg_reg.operating_mode_field ==
			dcr_pkg::MODE_SELFCAL) begin
			ocal_reg <= CAL_OFFSET;
			gcal_reg <= CAL_GAIN;
		end
	end

	// read path: next bit is put out right after the host samples one
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			tx_reg <= 8'h00;
			oe_reg <= 1'b0;
			sdo_reg <= 1'b0;
		end else if (cs_n_s2) begin
			oe_reg <= 1'b0;
		end else if (byte_done && state_reg == dcr_pkg::ST_CMD) begin
			if (cmd_rd && cmd_mb != dcr_pkg::MB_RESERVED) begin
				tx_reg <= map_byte(cmd_addr, code_reg, cfg_read(cfg_reg),
					ocal_reg, gcal_reg);
				sdo_reg <= tx_bit(map_byte(cmd_addr, code_reg,
					cfg_read(cfg_reg), ocal_reg, gcal_reg), 3'h0,
					cfg_reg.bit_order_sel);
				oe_reg <= 1'b1;
			end
		end else if (fall && state_reg == dcr_pkg::ST_RDATA) begin
			if (!byte_done) begin
				sdo_reg <= tx_bit(tx_reg, bit_reg + 3'h1, lsb_first);
			end else if (left_reg != 2'h0) begin
				tx_reg <= map_byte(addr_step, code_reg, cfg_read(cfg_reg),
					ocal_reg, gcal_reg);
				sdo_reg <= tx_bit(map_byte(addr_step, code_reg,
					cfg_read(cfg_reg), ocal_reg, gcal_reg), 3'h0,
					lsb_first);
			end else begin
				oe_reg <= 1'b0;
			end
		end
	end

	// conversion code and fast settling
	logic [19:0] out_next, step;
	assign out_next = (cfg_eff.resolution_sel ? code_eff[23:4] :
		{code_eff[23:8], dcr_pkg::PAD16}) ^
		{~cfg_eff.code_format_sel, 19'h00000};
	assign step = (out_next > out_reg) ? out_next - out_reg :
		out_reg - out_next;

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			out_reg <= {1'b1, 19'h00000};
			upd_reg <= 1'b0;
		end else begin
			upd_reg <= code_upd;
			if (code_upd) begin
				out_reg <= out_next;
			end
		end
	end

	// settling is timed, not measured; the analog side is not observed
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			hold_reg <= 16'h0000;
		end else if (code_upd &&
			step > 20'(dcr_pkg::STEP_THRESH_CODES)) begin
			hold_reg <= 16'(SETTLE_CYCLES);
		end else if (hold_reg != 16'h0000) begin
			hold_reg <= hold_reg - 16'h0001;
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			fast_reg <= 1'b0;
		end else if (cfg_reg.fast_settle_disable) begin
			fast_reg <= 1'b0;
		end else if (cfg_reg.adaptive_filter_ctl) begin
			fast_reg <= 1'b1;
		end else begin
			fast_reg <= (hold_reg != 16'h0000);
		end
	end

	assign SDIO_OUT = sdo_reg;
	assign SDIO_OE = oe_reg;
	assign CODE_OUT = out_reg;
	assign CODE_UPDATE = upd_reg;
	assign FAST_SETTLE = fast_reg;
	assign OP_MODE = cfg_reg.operating_mode_field;
	assign CAL_CONNECT = cfg_reg.cal_output_connect;
	assign OFFSET_CAL = ocal_reg;
	assign GAIN_CAL = gcal_reg;
endmodule
`default_nettype wire

/* dcr_top_monitor.sv */
// Purpose: port checks for the converter register map
// Assumes: host keeps each SCLK phase at least 4 MCLK long
// Notes: CS_N sync depth sets the 3 and 4 cycle look-backs
`timescale 1ns/1ps
`default_nettype none
module dcr_top_monitor (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic CS_N,
	input wire logic SDIO_OE,
	input wire logic CAL_DONE,
	input wire logic [23:0] CAL_OFFSET,
	input wire logic [23:0] CAL_GAIN,
	input wire logic [19:0] CODE_OUT,
	input wire logic CODE_UPDATE,
	input wire logic FAST_SETTLE,
	input wire logic [1:0] OP_MODE,
	input wire logic [23:0] OFFSET_CAL,
	input wire logic [23:0] GAIN_CAL
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);
	AST_UPD_PULSE: assert property (CODE_UPDATE |=> !CODE_UPDATE)
		else $error("code update pulse too long");
	AST_CODE_CHG: assert property ($changed(CODE_OUT) |-> CODE_UPDATE)
		else $error("code output moved without update");
	AST_UPD_CAUSE: assert property (CODE_UPDATE |-> !$past(CS_N, 3))
		else $error("code update outside a command");
	AST_IDLE_NO_UPD: assert property (CS_N && $past(CS_N, 4)
		|-> !CODE_UPDATE)
		else $error("code update while deselected");
	AST_OE_DESEL: assert property (CS_N [*4] |-> !SDIO_OE)
		else $error("data pin driven while deselected");
	AST_OE_START: assert property ($rose(SDIO_OE)
		|-> !CS_N && !$past(CS_N, 3))
		else $error("read drive without selection");
	AST_CAL_LOAD: assert property (CAL_DONE && OP_MODE == 2'h1 && CS_N
		&& $past(CS_N, 4) |=> OP_MODE == 2'h0 && OFFSET_CAL == $past(CAL_OFFSET)
		&& GAIN_CAL == $past(CAL_GAIN))
		else $error("calibration results not taken");
	AST_CAL_IGN: assert property (CAL_DONE && OP_MODE != 2'h1 && CS_N
		&& $past(CS_N, 4) |=> $stable(OP_MODE) && $stable(OFFSET_CAL))
		else $error("calibration done acted outside self-cal");
	AST_CALREG_IDLE: assert property (CS_N && $past(CS_N, 4)
		&& !$past(CAL_DONE) |-> $stable(OFFSET_CAL) && $stable(GAIN_CAL))
		else $error("calibration register moved while idle");
	AST_FAST_CAUSE: assert property ($rose(FAST_SETTLE) |-> !$past(CS_N, 3))
		else $error("fast settle raised without a command");
	cover property (CODE_UPDATE);
	cover property ($rose(SDIO_OE));
	cover property (CAL_DONE && OP_MODE == 2'h1);
	cover property ($fell(FAST_SETTLE));
endmodule
bind dcr_top dcr_top_monitor dcr_top_monitor_i (.MCLK(MCLK), .RST(RST),
	.CS_N(CS_N), .SDIO_OE(SDIO_OE), .CAL_DONE(CAL_DONE),
	.CAL_OFFSET(CAL_OFFSET), .CAL_GAIN(CAL_GAIN), .CODE_OUT(CODE_OUT),
	.CODE_UPDATE(CODE_UPDATE), .FAST_SETTLE(FAST_SETTLE), .OP_MODE(OP_MODE),
	.OFFSET_CAL(OFFSET_CAL), .GAIN_CAL(GAIN_CAL));
`default_nettype wire

/* testbench.sv */
// Purpose: self-checking bench for the converter register map
// Assumes: settle timer shortened to 20; order bits set only in t_order
// Notes: register traffic goes only through the host model
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic cal_done = 1'b0;
	logic [23:0] cal_offset = 24'h000000;
	logic [23:0] cal_gain = 24'h000000;
	logic sclk, cs_n, host_drv, sdio_out, sdio_oe, code_update, fast_settle;
	logic cal_connect;
	logic [1:0] op_mode;
	logic [19:0] code_out;
	logic [23:0] offset_cal, gain_cal, rd;
	wire logic sdio_line = sdio_oe ? sdio_out : host_drv;
	int err_count = 0;
	int compares = 0;
	int upd_count = 0;
	int cycles = 0;
	always #20 mclk = ~mclk;
	dcr_top #(.SETTLE_CYCLES(20)) dcr_top_i (.MCLK(mclk), .RST(rst),
		.SCLK(sclk), .CS_N(cs_n), .SDIO_IN(sdio_line), .SDIO_OUT(sdio_out),
		.SDIO_OE(sdio_oe), .CAL_DONE(cal_done), .CAL_OFFSET(cal_offset),
		.CAL_GAIN(cal_gain), .CODE_OUT(code_out), .CODE_UPDATE(code_update),
		.FAST_SETTLE(fast_settle), .OP_MODE(op_mode),
		.CAL_CONNECT(cal_connect), .OFFSET_CAL(offset_cal),
		.GAIN_CAL(gain_cal));
	dcr_host_model dcr_host_model_i (.MCLK(mclk), .SCLK(sclk), .CS_N(cs_n),
		.SDIO_DRV(host_drv), .SDIO_LINE(sdio_line));
	// timeout well above the roughly 6000 cycles the sequence needs
	always @(posedge mclk) begin
		cycles++;
		if (code_update === 1'b1) upd_count++;
		if (cycles == 30000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic check(input string what, input logic [23:0] seen,
		input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cmd(input logic [7:0] c, input int nb, input logic [23:0] d);
		dcr_host_model_i.xfer(c, nb, d, rd);
	endtask
	task automatic complete_run();
		if (err_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic t_reset();
		check("mode", {22'h0, op_mode}, 24'h000002);
		check("code", {4'h0, code_out}, 24'h080000);
		check("gain", gain_cal, 24'h800000);
		cmd(8'ha4, 2, 24'h0);
		check("cfg reset", rd, 24'h002802);
		cmd(8'h24, 2, 24'h002000);
		cmd(8'ha4, 2, 24'h0);
		check("cfg normal", rd, 24'h002800);
		check("mode normal", {22'h0, op_mode}, 24'h000000);
	endtask
	task automatic t_code16();
		int u;
		u = upd_count;
		cmd(8'h40, 3, 24'h123456);
		check("code16", {4'h0, code_out}, 24'h092340);
		check("upd over", {23'h0, code_update}, 24'h000000);
		check("upd count", 24'(upd_count - u), 24'h000001);
		cmd(8'h02, 1, 24'h0000ff);
		check("low byte", 24'(upd_count - u), 24'h000001);
		check("code16 kept", {4'h0, code_out}, 24'h092340);
		cmd(8'hc0, 3, 24'h0);
		check("code read", rd, 24'h1234ff);
	endtask
	task automatic t_code20();
		cmd(8'h24, 2, 24'h0020a0);
		cmd(8'h40, 3, 24'habcde0);
		check("code20 bin", {4'h0, code_out}, 24'h0abcde);
		cmd(8'h20, 2, 24'h001111);
		check("code20 part", {4'h0, code_out}, 24'h01111e);
		cmd(8'h60, 1, 24'h0000ff);
		check("refused", {4'h0, code_out}, 24'h01111e);
	endtask
	task automatic t_reserved();
		cmd(8'h03, 1, 24'h0000a5);
		cmd(8'hc2, 3, 24'h0);
		check("reserved", rd, 24'he00028);
	endtask
	task automatic t_fast();
		cmd(8'h24, 2, 24'h00a0a0);
		check("fast on", {23'h0, fast_settle}, 24'h000001);
		cmd(8'h24, 2, 24'h0020b0);
		check("fast off", {23'h0, fast_settle}, 24'h000000);
		cmd(8'h24, 2, 24'h0020a0);
		cmd(8'h40, 3, 24'hf00000);
		check("step fast", {23'h0, fast_settle}, 24'h000001);
		repeat (40) @(posedge mclk);
		check("settled", {23'h0, fast_settle}, 24'h000000);
	endtask
	task automatic t_cal();
		cmd(8'h48, 3, 24'h010203);
		check("offset wr", offset_cal, 24'h010203);
		cmd(8'h24, 2, 24'h0060a1);
		check("selfcal", {22'h0, op_mode}, 24'h000001);
		check("cal connect", {23'h0, cal_connect}, 24'h000001);
		cal_offset <= 24'h0a0b0c;
		cal_gain <= 24'h0d0e0f;
		cal_done <= 1'b1;
		@(posedge mclk);
		cal_done <= 1'b0;
		repeat (3) @(posedge mclk);
		check("cal mode", {22'h0, op_mode}, 24'h000000);
		check("cal off", offset_cal, 24'h0a0b0c);
		check("cal gain", gain_cal, 24'h0d0e0f);
		cal_offset <= 24'h111111;
		cal_done <= 1'b1;
		@(posedge mclk);
		cal_done <= 1'b0;
		repeat (3) @(posedge mclk);
		check("cal ignored", offset_cal, 24'h0a0b0c);
		cmd(8'h24, 2, 24'h0022a0);
		check("clr off", offset_cal, 24'h000000);
		check("clr gain", gain_cal, 24'h800000);
		check("cal disc", {23'h0, cal_connect}, 24'h000000);
		cmd(8'ha4, 2, 24'h0);
		check("clr reads 0", rd, 24'h0028a0);
	endtask
	// lsb-first bytes come back bit reversed through the msb-first host
	task automatic t_order();
		cmd(8'h24, 2, 24'h0020a4);
		cmd(8'ha4, 2, 24'h0);
		check("lsb read", rd, 24'h001425);
		cmd(8'h24, 2, 24'h000405);
		cmd(8'h24, 2, 24'h0020a8);
		cmd(8'ha5, 2, 24'h0);
		check("down read", rd, 24'h00a828);
		cmd(8'h25, 2, 24'h00e020);
		check("code clear", {4'h0, code_out}, 24'h000000);
		cmd(8'ha4, 2, 24'h0);
		check("clr bit 0", rd, 24'h0028a0);
		cmd(8'hc0, 3, 24'h0);
		check("code reg 0", rd, 24'h000000);
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		t_reset();
		t_code16();
		t_code20();
		t_reserved();
		t_fast();
		t_cal();
		t_order();
		complete_run();
	end
endmodule
`default_nettype wire
